// file: byte_wide_config_loader.sv
/*
 * byte-wide configuration loader: asynchronous peripheral front end
 * with its serializer, byte-per-clock slave front end with a byte fifo.
 * assumes every pin input is asynchronous to clk_sys; the config clock
 * input is sampled and edge-detected, never used as a clock.
 */
// What this block does
// - last byte: shift seven bits, hold bit 6
// - status read condition drives status byte
// - status bit7 ready, bits0-6 high
// - last byte completes start-up in one transfer
// - pattern 101 selects asynchronous peripheral mode
// - busy lasts 2 to 9 clock periods
// - byte slave: one byte per clock
// - constant-field check only, no crc
// - capture from second rising edge onward
// - accept only with chip select high, memory not full
// - serial out low two cycles after init, high when full
// - serial out status feeds next chip select
// - byte slave waits for completion pin high
// - unconnected completion pin: active once configured
// - completion pull-up on unless option disables it
// - pattern 010 selects byte slave mode
// - latch byte on trailing edge of write condition
// - busy on receipt, ready after buffer transfer
`timescale 1ns/1ps

module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module byte_wide_config_loader
    import config_loader_pkg::*;
(
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // mode and start-up pins
    input  wire logic [2:0] mode_select_pins,
    input  wire logic       init_pin,
    input  wire logic       last_byte,
    input  wire logic       memory_full,
    input  wire logic       config_done,
    input  wire logic       pullup_disable_opt,
    // processor strobes
    input  wire logic       chip_select_low_n,
    input  wire logic       chip_select_high,
    input  wire logic       read_strobe_n,
    input  wire logic       write_strobe_n,
    // data bus
    input  wire logic [7:0] config_data_bus_in,
    output logic      [7:0] config_data_bus_out,
    output logic            config_data_bus_oe,
    // configuration clock
    input  wire logic       config_clock_in,
    output logic            config_clock_out,
    output logic            config_clock_oe,
    // handshake, chain and completion
    output logic            ready_busy,
    output logic            serial_out,
    input  wire logic       done_in,
    output logic            done_out,
    output logic            done_oe,
    output logic            done_pullup_en,
    output logic            device_active,
    output logic            startup_complete,
    output logic            field_error,
    // configuration bytes toward the array
    output logic      [7:0] array_byte,
    output logic            array_valid,
    input  wire logic       array_ready
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    localparam int SW = 21;
    logic [SW-1:0] sync1;
    logic [SW-1:0] sync2;
    logic [2:0]    mode_s;
    logic          init_s, full_s, done_s, csl_s, csh_s, rd_stb_n, wr_stb_n, lclk_s;
    logic [7:0]    data_s;
    logic [1:0]    opt_sync;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sync1    <= '0;
            sync2    <= '0;
            opt_sync <= 2'h0;
        end else begin
            sync1 <= {mode_select_pins, init_pin, memory_full, done_in,
                      chip_select_low_n, chip_select_high, read_strobe_n,
                      write_strobe_n, config_clock_in, config_data_bus_in,
                      last_byte, config_done};
            sync2 <= sync1;
            opt_sync <= {opt_sync[0], pullup_disable_opt};
        end
    end
    assign {mode_s, init_s, full_s, done_s, csl_s, csh_s, rd_stb_n, wr_stb_n, lclk_s,
            data_s} = sync2[SW-1:2];

    logic is_async;
    logic is_slave;
    assign is_async = (mode_s == MODE_ASYNC_PERIPH);
    assign is_slave = (mode_s == MODE_BYTE_SLAVE);

    // ------------------------------------------------------------
    // status read
    // ------------------------------------------------------------
    logic rd_cond;
    assign rd_cond = is_async && !csl_s && csh_s && !rd_stb_n && wr_stb_n;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            config_data_bus_oe  <= 1'b0;
            config_data_bus_out <= 8'h00;
        end else begin
            config_data_bus_oe  <= rd_cond;
            config_data_bus_out <= rd_cond ? {ready_busy, STATUS_LOW_BITS} : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // write capture and input buffer
    // ------------------------------------------------------------
    logic       wr_cond, wr_prev, wr_end;
    logic [7:0] wr_data, in_buf;
    logic       buf_full;
    logic [1:0] buf_age;
    logic       take_buf;
    assign wr_cond = is_async && !csl_s && !wr_stb_n && rd_stb_n && csh_s;
    assign wr_end  = wr_prev && !wr_cond;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_prev <= 1'b0;
            wr_data <= 8'h00;
            in_buf  <= 8'h00;
        end else begin
            wr_prev <= wr_cond;
            if (wr_cond) begin
                wr_data <= data_s;
            end
            if (wr_end) begin
                in_buf <= wr_data;
            end
        end
    end

    // ------------------------------------------------------------
    // internal config clock generator
    // ------------------------------------------------------------
    logic [3:0] div;
    logic       gclk_run, rise_tick, fall_tick;
    ser_state_t ser_state;
    assign gclk_run  = buf_full || (ser_state == SER_SHIFT) || !config_clock_out;
    assign rise_tick = gclk_run && (div == 4'(GEN_CLK_HALF_CYCLES-1)) && !config_clock_out;
    assign fall_tick = gclk_run && (div == 4'(GEN_CLK_HALF_CYCLES-1)) && config_clock_out;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            div              <= 4'h0;
            config_clock_out <= 1'b1;
            config_clock_oe  <= 1'b0;
        end else begin
            config_clock_oe <= is_async;
            if (!gclk_run || div == 4'(GEN_CLK_HALF_CYCLES-1)) begin
                div <= 4'h0;
            end else begin
                div <= div + 4'h1;
            end
            if (rise_tick || fall_tick) begin
                config_clock_out <= !config_clock_out;  // stops high when idle
            end
        end
    end

    // ------------------------------------------------------------
    // handshake
    // ------------------------------------------------------------
    logic [3:0] bits_left;
    assign take_buf = rise_tick && buf_full && (buf_age == 2'd2) && (bits_left == 4'h0)
                      && (ser_state != SER_HOLD);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            buf_full   <= 1'b0;
            buf_age    <= 2'd0;
            ready_busy <= 1'b1;
        end else begin
            if (wr_end) begin
                buf_full   <= 1'b1;     // set wins over transfer
                buf_age    <= 2'd0;
                ready_busy <= 1'b0;
            end else if (take_buf) begin
                buf_full   <= 1'b0;
                ready_busy <= 1'b1;
            end else if (rise_tick && buf_full && buf_age != 2'd2) begin
                buf_age <= buf_age + 2'd1;  // at least two periods busy
            end
        end
    end

    // ------------------------------------------------------------
    // serializer
    // ------------------------------------------------------------
    logic [7:0] shifter;
    logic       is_last, ser_bit;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ser_state        <= SER_IDLE;
            shifter          <= 8'h00;
            bits_left        <= 4'h0;
            is_last          <= 1'b0;
            ser_bit          <= 1'b1;
            startup_complete <= 1'b0;
        end else begin
            case (ser_state)
                SER_IDLE, SER_SHIFT: begin
                    if (take_buf) begin
                        shifter   <= in_buf;
                        is_last   <= sync2[1];
                        bits_left <= sync2[1] ? LAST_BYTE_BITS : BYTE_BITS;
                        ser_state <= SER_SHIFT;
                    end else if (fall_tick && bits_left != 4'h0) begin
                        ser_bit   <= shifter[0];
                        shifter   <= {1'b0, shifter[7:1]};
                        bits_left <= bits_left - 4'h1;
                        if (bits_left == 4'h1) begin
                            ser_state <= is_last ? SER_HOLD : SER_IDLE;
                        end
                    end
                end
                SER_HOLD: begin
                    startup_complete <= 1'b1;  // holds bit 6 on serial out
                end
                default: begin
                    ser_state <= SER_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // byte slave: init delay, edge count, capture
    // ------------------------------------------------------------
    logic       init_prev, armed, lclk_prev, lclk_rise, seen_first;
    logic [1:0] init_cnt;
    logic       link_status, accept, fifo_in_ready;
    assign lclk_rise = lclk_s && !lclk_prev;
    assign accept    = is_slave && armed && seen_first && lclk_rise && csh_s && !full_s
                       && fifo_in_ready;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            init_prev   <= 1'b0;
            init_cnt    <= 2'd0;
            armed       <= 1'b0;
            link_status <= 1'b1;
            lclk_prev   <= 1'b0;
            seen_first  <= 1'b0;
        end else begin
            init_prev <= init_s;
            lclk_prev <= lclk_s;
            if (init_s && !init_prev) begin
                init_cnt <= 2'd1;
            end else if (init_cnt != 2'd0 && init_cnt != 2'(INIT_DELAY_CYCLES)) begin
                init_cnt <= init_cnt + 2'd1;
            end
            if (init_cnt == 2'(INIT_DELAY_CYCLES) && !armed) begin
                armed       <= 1'b1;
                link_status <= 1'b0;
            end else if (armed && full_s) begin
                link_status <= 1'b1;             // enables next device
            end
            if (armed && lclk_rise) begin
                seen_first <= 1'b1;              // first edge only arms capture
            end
        end
    end

    // ------------------------------------------------------------
    // constant-field check
    // ------------------------------------------------------------
    logic [3:0] frame_pos;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            frame_pos   <= 4'h0;
            field_error <= 1'b0;
        end else if (accept) begin
            frame_pos <= (frame_pos == FRAME_BYTES - 4'h1) ? 4'h0 : frame_pos + 4'h1;
            if (frame_pos == 4'h0 && data_s != FRAME_HEAD) begin
                field_error <= 1'b1;             // no crc is computed
            end
        end
    end

    byte_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .in_valid  (accept),                     // whole byte per edge
        .in_ready  (fifo_in_ready),
        .in_data   (data_s),
        .out_valid (array_valid),
        .out_ready (array_ready),
        .out_data  (array_byte)
    );

    // ------------------------------------------------------------
    // serial out and completion
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            serial_out     <= 1'b1;
            done_out       <= 1'b0;
            done_oe        <= 1'b1;
            done_pullup_en <= 1'b1;
            device_active  <= 1'b0;
        end else begin
            serial_out     <= is_slave ? link_status : ser_bit;
            done_oe        <= !sync2[0];
            done_pullup_en <= !opt_sync[1];
            device_active  <= sync2[0] && (done_s || !is_slave);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [7:0] busy_cyc;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            busy_cyc <= 8'h00;
        end else if (ready_busy) begin
            busy_cyc <= 8'h00;
        end else if (busy_cyc != 8'hFF) begin
            busy_cyc <= busy_cyc + 8'h01;
        end
    end

    sequence s_write_end;
        wr_end;
    endsequence
    sequence s_busy_then_ready;
        !ready_busy ##[1:80] ready_busy;
    endsequence

    chk_status_byte: assert property (@(posedge clk_sys) disable iff (rst)
        rd_cond |=> config_data_bus_oe && config_data_bus_out[6:0] == STATUS_LOW_BITS
                    && config_data_bus_out[STATUS_READY_BIT] == $past(ready_busy))
        else $error("status byte wrong");
    chk_bus_release: assert property (@(posedge clk_sys) disable iff (rst)
        !rd_cond |=> !config_data_bus_oe)
        else $error("bus driven outside status read");
    chk_busy_on_write: assert property (@(posedge clk_sys) disable iff (rst)
        s_write_end |=> s_busy_then_ready)
        else $error("handshake not busy then ready after write");
    chk_busy_length: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(ready_busy) |-> busy_cyc >= 8'(BUSY_MIN_CYCLES)
                              && busy_cyc <= 8'(BUSY_MAX_CYCLES))
        else $error("busy length out of range");
    chk_last_hold: assert property (@(posedge clk_sys) disable iff (rst)
        ser_state == SER_HOLD && config_clock_out
        |=> ser_state == SER_HOLD && config_clock_out && $stable(ser_bit))
        else $error("hold state not stable with clock high");
    chk_accept_gate: assert property (@(posedge clk_sys) disable iff (rst)
        accept |-> csh_s && !full_s && is_slave)
        else $error("byte accepted while not enabled");
    chk_first_edge: assert property (@(posedge clk_sys) disable iff (rst)
        (armed && lclk_rise && !seen_first) |-> !accept)
        else $error("first edge captured a byte");
    chk_init_low: assert property (@(posedge clk_sys) disable iff (rst)
        (is_slave && init_s && !init_prev && !armed && !full_s)[*1] ##1 !full_s[*3]
        |=> !link_status)
        else $error("serial out not low after init");
    chk_active_sync: assert property (@(posedge clk_sys) disable iff (rst)
        (is_slave && !done_s) |=> !device_active)
        else $error("active before completion pin high");
endmodule

// file: byte_wide_config_loader_tb.sv
/*
 * bench for the loader: host writes and status reads, then byte slave loading.
 * assumes the package, the design files and link_source are compiled first.
 */
`timescale 1ns/1ps
module byte_wide_config_loader_tb;
    import config_loader_pkg::*;
    logic       clk_sys = 0, rst = 1, init_pin = 1, last_byte = 0, memory_full = 0;
    logic       config_done = 0, pullup_disable_opt = 0, done_ext = 1, array_ready = 0;
    logic       chip_select_low_n = 1, chip_select_high = 1;
    logic       read_strobe_n = 1, write_strobe_n = 1;
    logic [2:0] mode_select_pins = MODE_ASYNC_PERIPH;
    logic [7:0] host_data = 8'h00, bus_out, array_byte, q [10];
    logic       bus_oe, clk_out, ready_busy, serial_out, done_oe, pull_en;
    logic       device_active, startup_complete, field_error, array_valid, link_clk;
    logic [7:0] link_data, bus_level;
    logic       done_level;
    int         error_cnt = 0, checks_done = 0;
    always #4 clk_sys = ~clk_sys;
    // ------------------------------------------------------------
    // shared pin levels
    // ------------------------------------------------------------
    assign bus_level  = bus_oe ? bus_out :
                        (mode_select_pins == MODE_BYTE_SLAVE ? link_data : host_data);
    assign done_level = done_oe ? 1'b0 : done_ext;
    link_source src (.link_clk(link_clk), .link_data(link_data));
    byte_wide_config_loader dut (.clk_sys(clk_sys), .rst(rst),
        .mode_select_pins(mode_select_pins), .init_pin(init_pin), .last_byte(last_byte),
        .memory_full(memory_full), .config_done(config_done),
        .pullup_disable_opt(pullup_disable_opt), .chip_select_low_n(chip_select_low_n),
        .chip_select_high(chip_select_high), .read_strobe_n(read_strobe_n),
        .write_strobe_n(write_strobe_n), .config_data_bus_in(bus_level),
        .config_data_bus_out(bus_out), .config_data_bus_oe(bus_oe),
        .config_clock_in(link_clk), .config_clock_out(clk_out), .config_clock_oe(),
        .ready_busy(ready_busy), .serial_out(serial_out), .done_in(done_level),
        .done_out(), .done_oe(done_oe), .done_pullup_en(pull_en),
        .device_active(device_active), .startup_complete(startup_complete),
        .field_error(field_error), .array_byte(array_byte), .array_valid(array_valid),
        .array_ready(array_ready));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic status_read(input logic [7:0] exp, input logic oe);
        chip_select_low_n = 0;
        read_strobe_n = 0;
        cyc(4);
        chk("status drive", 8'(bus_oe), 8'(oe));
        if (oe)
            chk("status byte", bus_out, exp);
        chip_select_low_n = 1;
        read_strobe_n = 1;
        cyc(4);
        chk("bus released", 8'(bus_oe), 8'h00);
    endtask
    task automatic host_write(input logic [7:0] b, input logic fin);
        int busy;
        host_data = b;
        last_byte = fin;
        chip_select_low_n = 0;
        write_strobe_n = 0;
        cyc(13);
        write_strobe_n = 1;
        chip_select_low_n = 1;
        host_data = ~b;
        cyc(5);
        chk("busy after write", 8'(ready_busy), 8'h00);
        status_read(8'h7F, 1);
        busy = 10;
        while (ready_busy !== 1'b1 && busy < 200) begin
            busy++;
            cyc(1);
        end
        chk("busy span", 8'(busy >= BUSY_MIN_CYCLES && busy <= BUSY_MAX_CYCLES), 8'h01);
        cyc(8);
    endtask
    initial begin
        #100us;
        error_cnt++;
        end_of_test();
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        void'($urandom(39));
        cyc(5);
        rst = 0;
        cyc(2);
        chk("ready at reset", 8'(ready_busy), 8'h01);
        chk("pullup at reset", 8'(pull_en), 8'h01);
        status_read(8'hFF, 1);
        $display("test reset and status done");
        for (int i = 0; i < 3; i++)
            q[i] = 8'($urandom);
        host_write(q[0], 0);
        host_write(q[1], 0);
        host_write(q[2], 1);
        for (int i = 0; i < 200 && !startup_complete; i++)
            cyc(1);
        cyc(16);
        chk("startup done", 8'(startup_complete), 8'h01);
        chk("clock halted", 8'(clk_out), 8'h01);
        chk("held bit", 8'(serial_out), 8'(q[2][6]));
        $display("test host writes done");
        mode_select_pins = MODE_BYTE_SLAVE;
        init_pin = 0;
        rst = 1;
        cyc(2);
        rst = 0;
        cyc(2);
        init_pin = 1;
        cyc(8);
        chk("chain low", 8'(serial_out), 8'h00);
        status_read(8'h00, 0);
        for (int i = 0; i < 10; i++)
            q[i] = (i == 1) ? FRAME_HEAD : 8'($urandom);
        for (int i = 0; i < 10; i++)
            src.send(q[i]);
        cyc(4);
        chk("frame check", 8'(field_error), 8'h00);
        array_ready = 1;
        for (int i = 1; i < 9; i++) begin
            for (int j = 0; j < 20 && !array_valid; j++)
                cyc(1);
            chk("slave byte", array_byte, q[i]);
            cyc(1);
        end
        cyc(2);
        chk("overflow dropped", 8'(array_valid), 8'h00);
        src.send(8'h00);
        cyc(4);
        chk("frame error", 8'(field_error), 8'h01);
        chip_select_high = 0;
        src.send(8'hA5);
        cyc(4);
        chk("deselected", 8'(array_valid), 8'h00);
        chip_select_high = 1;
        memory_full = 1;
        src.send(8'h3C);
        cyc(4);
        chk("full refused", 8'(array_valid), 8'h00);
        chk("chain high", 8'(serial_out), 8'h01);
        $display("test byte slave done");
        config_done = 1;
        done_ext = 0;
        cyc(6);
        chk("held inactive", 8'(device_active), 8'h00);
        done_ext = 1;
        cyc(6);
        chk("active", 8'(device_active), 8'h01);
        pullup_disable_opt = 1;
        cyc(4);
        chk("pullup off", 8'(pull_en), 8'h00);
        $display("test completion done");
        end_of_test();
    end
endmodule

// file: config_loader_pkg.sv
/*
 * constants shared by the byte-wide configuration loader.
 * assumes a 125 MHz system clock; all pin levels are sampled on it.
 */
package config_loader_pkg;

    // ------------------------------------------------------------
    // mode select patterns
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_ASYNC_PERIPH = 3'b101;
    localparam logic [2:0] MODE_BYTE_SLAVE   = 3'b010;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_SYS_NS        = 8;
    localparam int GEN_CLK_PERIOD_NS   = 64;
    localparam int GEN_CLK_HALF_CYCLES = GEN_CLK_PERIOD_NS / (2 * CLK_SYS_NS);
    localparam int BUSY_MIN_PERIODS    = 2;
    localparam int BUSY_MAX_PERIODS    = 9;
    localparam int BUSY_MIN_CYCLES     = BUSY_MIN_PERIODS * GEN_CLK_PERIOD_NS / CLK_SYS_NS;
    localparam int BUSY_MAX_CYCLES     = BUSY_MAX_PERIODS * GEN_CLK_PERIOD_NS / CLK_SYS_NS;
    localparam int INIT_DELAY_CYCLES = 2;

    // ------------------------------------------------------------
    // byte and status layout
    // ------------------------------------------------------------
    localparam logic [3:0] BYTE_BITS       = 4'h8;
    localparam logic [3:0] LAST_BYTE_BITS  = 4'h7;
    localparam int         STATUS_READY_BIT = 7;
    localparam logic [6:0] STATUS_LOW_BITS = 7'h7F;

    // ------------------------------------------------------------
    // frame constant-field check and buffering
    // ------------------------------------------------------------
    localparam logic [3:0] FRAME_BYTES = 4'h8;
    localparam logic [7:0] FRAME_HEAD  = 8'h5A;
    localparam int         FIFO_WIDTH  = 8;
    localparam int         FIFO_DEPTH  = 8;

    // ------------------------------------------------------------
    // serializer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SER_IDLE  = 2'b00,
        SER_SHIFT = 2'b01,
        SER_HOLD  = 2'b10
    } ser_state_t;

endpackage

// file: link_source.sv
/*
 * far-side model for byte slave mode: drives the link clock and data byte.
 * assumes the bench calls send once per byte; the clock stands still between calls.
 */
`timescale 1ns/1ps
module link_source (
    // link pins
    output logic       link_clk,
    output logic [7:0] link_data
);
    initial begin
        link_clk  = 1'b0;
        link_data = 8'h00;
    end
    // ------------------------------------------------------------
    // one byte per period, set up half a period before the rise
    // ------------------------------------------------------------
    task automatic send(input logic [7:0] b);
        link_data = b;
        #40 link_clk = 1'b1;
        #20 link_data = ~b;
        #20 link_clk = 1'b0;
    endtask
endmodule
